// ==== hdl/pxb_cfg.svh ====
// Purpose: Constants for the port I/O and crossbar configuration block
// Assumes: Two ports of eight pins, flattened as pin = port*8 + bit
// Notes: Slot numbers give crossbar priority order
`ifndef PXB_CFG_SVH
`define PXB_CFG_SVH

`define PXB_NPINS 16
`define PXB_NSLOTS 12
`define PXB_PIN_W 4
`define PXB_SLOT_W 4

// Peripheral slots in priority order
`define PXB_SLOT_TX 4'h0
`define PXB_SLOT_RX 4'h1
`define PXB_SLOT_SCK 4'h2
`define PXB_SLOT_MISO 4'h3
`define PXB_SLOT_MOSI 4'h4
`define PXB_SLOT_NSS 4'h5
`define PXB_SLOT_SDA 4'h6
`define PXB_SLOT_SCL 4'h7
`define PXB_SLOT_CAPTURE_COMPARE_OUT_0 4'h8
`define PXB_SLOT_CAPTURE_COMPARE_OUT_1 4'h9
`define PXB_SLOT_CAPTURE_COMPARE_OUT_2 4'ha
`define PXB_SLOT_ECI 4'hb
`define PXB_FIRST_FLOAT_SLOT 5'h02
`define PXB_SLOT_END 5'h0c

// Fixed UART pins, port 0 bits 4 and 5
`define PXB_UART_TX_PIN 4'h4
`define PXB_UART_RX_PIN 4'h5

// Capture/compare enable codes
`define PXB_CCA_ONE 2'h1
`define PXB_CCA_TWO 2'h2
`define PXB_CCA_THREE 2'h3

// Reset values
`define PXB_RST_INPUT_MODE 16'hffff
`define PXB_RST_OUTPUT_MODE 16'h0000
`define PXB_RST_SKIP 16'h0000
`define PXB_RST_LATCH 16'hffff
`define PXB_RST_PULLUP 16'hffff
`define PXB_RST_RX_EN 16'hffff
`define PXB_ALL_ZERO 16'h0000
`define PXB_SLOT_IDLE 12'hfff

`endif

// ==== hdl/pxb_pkg.sv ====
// Purpose: Types shared by the port I/O and crossbar configuration block
// Assumes: pxb_cfg.svh holds all figures
// Notes: None
`include "pxb_cfg.svh"
package pxb_pkg;

	// Configuration bits as software leaves them
	typedef struct packed {
		logic [`PXB_NPINS-1:0] port_input_mode_reg;
		logic [`PXB_NPINS-1:0] port_output_mode_reg;
		logic [`PXB_NPINS-1:0] port_skip_reg;
		logic [`PXB_NPINS-1:0] port_latch_reg;
		logic uart_en;
		logic spi_en;
		logic spi_4wire;
		logic smbus_en;
		logic [1:0] cca_mode;
		logic eci_en;
		logic crossbar_enable_bit;
		logic weak_pullup_disable_bit;
	} pxb_cfg_t;

	// Drive request of each peripheral slot
	typedef struct packed {
		logic [`PXB_NSLOTS-1:0] dout;
		logic [`PXB_NSLOTS-1:0] oe;
	} pxb_periph_t;

endpackage

// ==== hdl/pxb_alloc.sv ====
// Purpose: Priority crossbar pin allocation
// Assumes: Requests and skip bits are stable register copies
// Notes: Purely combinational
`timescale 1ns/1ps
`include "pxb_cfg.svh"
module pxb_alloc (
	input wire logic [`PXB_NSLOTS-1:0] req,
	input wire logic [`PXB_NPINS-1:0] skip,
	output logic [`PXB_NPINS-1:0] pin_taken,
	output logic [`PXB_NPINS*`PXB_SLOT_W-1:0] pin_slot
);

	logic [4:0] next_slot;
	logic found;

	always_comb begin
		pin_taken = '0;
		pin_slot = '0;
		next_slot = `PXB_FIRST_FLOAT_SLOT;
		found = 1'b0;
		// RULE_15 UART fixed pins
		if (req[`PXB_SLOT_TX]) begin
			pin_taken[`PXB_UART_TX_PIN] = 1'b1;
			pin_slot[`PXB_UART_TX_PIN*`PXB_SLOT_W +: `PXB_SLOT_W] = `PXB_SLOT_TX;
		end
		if (req[`PXB_SLOT_RX]) begin
			pin_taken[`PXB_UART_RX_PIN] = 1'b1;
			pin_slot[`PXB_UART_RX_PIN*`PXB_SLOT_W +: `PXB_SLOT_W] = `PXB_SLOT_RX;
		end
		for (int p = 0; p < `PXB_NPINS; p++) begin
			// RULE_17 skipped pins passed over
			if (!skip[p] && !pin_taken[p]) begin
				found = 1'b0;
				// RULE_16 lowest free pin
				for (int s = `PXB_FIRST_FLOAT_SLOT; s < `PXB_NSLOTS; s++) begin
					if (!found && 5'(s) >= next_slot && req[s]) begin
						found = 1'b1;
						pin_taken[p] = 1'b1;
						pin_slot[p*`PXB_SLOT_W +: `PXB_SLOT_W] = `PXB_SLOT_W'(s);
						next_slot = 5'(s + 1);
					end
				end
			end
		end
	end

endmodule

// ==== hdl/pxb_port_io.sv ====
// Purpose: Port pin modes, weak pullups and priority crossbar routing
// Assumes: Configuration and peripheral signals come from CORE_CLK logic
// Notes: Pin inputs are synchronised before use; all outputs registered
//
// How it works
// RULE_01 - Analog pin loses weak pullup, output driver and input receiver.
// RULE_02 - Input-mode bit one means digital, zero means analog.
// RULE_03 - Reset puts every pin in digital input mode.
// RULE_04 - Software writes latch one for each analog pin.
// RULE_05 - Open-drain or push-pull chosen per pin, never automatically except SMBus pins.
// RULE_06 - SMBus data and clock pins always drive open-drain.
// RULE_07 - Pullup disable bit low enables pullups on open-drain pins only.
// RULE_08 - Pullup switched off on a pin driving zero.
// RULE_09 - Crossbar enable bit set activates peripheral routing.
// RULE_10 - Crossbar disabled: all pins are plain port inputs.
// RULE_11 - Crossbar disabled: every output driver held off.
// RULE_12 - Software sets modes, skips, assignments, then crossbar enable.
// RULE_13 - Software should skip every analog pin.
// RULE_14 - Analog use of digital pins allowed but not advised.
// RULE_15 - UART transmit and receive take port 0 pins 4 and 5.
// RULE_16 - SPI, SMBus, capture/compare fill lowest free pins; NSS in 4-wire only.
// RULE_17 - Skipped pins passed over by crossbar, stay usable otherwise.
`timescale 1ns/1ps
`include "pxb_cfg.svh"
module pxb_port_io (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire pxb_pkg::pxb_cfg_t CFG,
	input wire pxb_pkg::pxb_periph_t PERIPH,
	output logic [`PXB_NSLOTS-1:0] PERIPH_IN,
	input wire logic [`PXB_NPINS-1:0] PIN_IN,
	output logic [`PXB_NPINS-1:0] PIN_OUT,
	output logic [`PXB_NPINS-1:0] PIN_OE,
	output logic [`PXB_NPINS-1:0] PIN_PULLUP,
	output logic [`PXB_NPINS-1:0] PIN_RX_EN,
	output logic [`PXB_NPINS-1:0] PIN_ROUTED
);

	// ==========================================================
	// Helpers
	// ==========================================================
	// Open-drain drive: only ever pulls low
	function automatic logic od_enable(input logic want_oe, input logic value);
		od_enable = want_oe & ~value;
	endfunction

	function automatic logic [`PXB_SLOT_W-1:0] slot_of(
		input logic [`PXB_NPINS*`PXB_SLOT_W-1:0] map, input int p);
		slot_of = map[p*`PXB_SLOT_W +: `PXB_SLOT_W];
	endfunction

	// ==========================================================
	// Pin input synchroniser
	// ==========================================================
	logic [`PXB_NPINS-1:0] pin_meta;
	logic [`PXB_NPINS-1:0] pin_sync;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= PIN_IN;
			pin_sync <= pin_meta;
		end
	end

	// ==========================================================
	// Configuration copy
	// ==========================================================
	pxb_pkg::pxb_cfg_t cfg;
	pxb_pkg::pxb_cfg_t next_cfg;

	always_comb begin
		next_cfg = CFG;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			// RULE_03 digital inputs at reset
			cfg.port_input_mode_reg <= `PXB_RST_INPUT_MODE;
			cfg.port_output_mode_reg <= `PXB_RST_OUTPUT_MODE;
			cfg.port_skip_reg <= `PXB_RST_SKIP;
			cfg.port_latch_reg <= `PXB_RST_LATCH;
			cfg.uart_en <= 1'b0;
			cfg.spi_en <= 1'b0;
			cfg.spi_4wire <= 1'b0;
			cfg.smbus_en <= 1'b0;
			cfg.cca_mode <= 2'h0;
			cfg.eci_en <= 1'b0;
			cfg.crossbar_enable_bit <= 1'b0;
			cfg.weak_pullup_disable_bit <= 1'b0;
		end else begin
			cfg <= next_cfg;
		end
	end

	// ==========================================================
	// Slot requests and allocation
	// ==========================================================
	logic [`PXB_NSLOTS-1:0] req;
	logic [`PXB_NPINS-1:0] pin_taken;
	logic [`PXB_NPINS*`PXB_SLOT_W-1:0] pin_slot;

	always_comb begin
		req = '0;
		req[`PXB_SLOT_TX] = cfg.uart_en;
		req[`PXB_SLOT_RX] = cfg.uart_en;
		req[`PXB_SLOT_SCK] = cfg.spi_en;
		req[`PXB_SLOT_MISO] = cfg.spi_en;
		req[`PXB_SLOT_MOSI] = cfg.spi_en;
		// RULE_16 NSS only 4-wire
		req[`PXB_SLOT_NSS] = cfg.spi_en & cfg.spi_4wire;
		req[`PXB_SLOT_SDA] = cfg.smbus_en;
		req[`PXB_SLOT_SCL] = cfg.smbus_en;
		req[`PXB_SLOT_CAPTURE_COMPARE_OUT_0] = cfg.cca_mode >= `PXB_CCA_ONE;
		req[`PXB_SLOT_CAPTURE_COMPARE_OUT_1] = cfg.cca_mode >= `PXB_CCA_TWO;
		req[`PXB_SLOT_CAPTURE_COMPARE_OUT_2] = cfg.cca_mode == `PXB_CCA_THREE;
		req[`PXB_SLOT_ECI] = cfg.eci_en;
	end

	pxb_alloc u_alloc (
		.req(req),
		.skip(cfg.port_skip_reg),
		.pin_taken(pin_taken),
		.pin_slot(pin_slot)
	);

	// ==========================================================
	// Pin drive and pullup
	// ==========================================================
	logic [`PXB_NPINS-1:0] next_pin_out;
	logic [`PXB_NPINS-1:0] next_pin_oe;
	logic [`PXB_NPINS-1:0] next_pin_pullup;
	logic [`PXB_NPINS-1:0] next_pin_rx_en;
	logic [`PXB_NPINS-1:0] next_pin_routed;
	logic [`PXB_NSLOTS-1:0] next_periph_in;

	always_comb begin
		logic digital;
		logic open_drain;
		logic routed;
		logic [`PXB_SLOT_W-1:0] s;
		logic want_oe;
		logic value;
		digital = 1'b0;
		open_drain = 1'b0;
		routed = 1'b0;
		s = '0;
		want_oe = 1'b0;
		value = 1'b0;
		next_pin_out = '0;
		next_pin_oe = '0;
		next_pin_pullup = '0;
		next_pin_rx_en = '0;
		next_pin_routed = '0;
		next_periph_in = `PXB_SLOT_IDLE;
		for (int p = 0; p < `PXB_NPINS; p++) begin
			// RULE_02 one means digital
			digital = cfg.port_input_mode_reg[p];
			s = slot_of(pin_slot, p);
			// RULE_09 routing only when enabled
			routed = cfg.crossbar_enable_bit & pin_taken[p];
			// RULE_05 per-pin output mode
			open_drain = ~cfg.port_output_mode_reg[p];
			// RULE_06 SMBus forced open-drain
			if (routed && (s == `PXB_SLOT_SDA || s == `PXB_SLOT_SCL)) begin
				open_drain = 1'b1;
			end
			if (routed) begin
				want_oe = PERIPH.oe[s];
				value = PERIPH.dout[s];
			end else begin
				want_oe = 1'b1;
				value = cfg.port_latch_reg[p];
			end
			// RULE_10 disabled crossbar leaves inputs
			if (!cfg.crossbar_enable_bit) begin
				// RULE_11 drivers held off
				want_oe = 1'b0;
			end
			// RULE_01 analog pin fully isolated
			if (!digital) begin
				want_oe = 1'b0;
			end
			if (open_drain) begin
				next_pin_oe[p] = od_enable(want_oe, value);
				next_pin_out[p] = 1'b0;
			end else begin
				next_pin_oe[p] = want_oe;
				next_pin_out[p] = value;
			end
			// RULE_07 pullup on open-drain only
			next_pin_pullup[p] = digital & open_drain & ~cfg.weak_pullup_disable_bit;
			// RULE_08 no pullup while driving low
			if (next_pin_oe[p] && !next_pin_out[p]) begin
				next_pin_pullup[p] = 1'b0;
			end
			// RULE_01 receiver off in analog mode
			next_pin_rx_en[p] = digital;
			next_pin_routed[p] = routed;
			if (routed && digital) begin
				next_periph_in[s] = pin_sync[p];
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			PIN_OUT <= `PXB_ALL_ZERO;
			PIN_OE <= `PXB_ALL_ZERO;
			PIN_PULLUP <= `PXB_RST_PULLUP;
			PIN_RX_EN <= `PXB_RST_RX_EN;
			PIN_ROUTED <= `PXB_ALL_ZERO;
			PERIPH_IN <= `PXB_SLOT_IDLE;
		end else begin
			PIN_OUT <= next_pin_out;
			PIN_OE <= next_pin_oe;
			PIN_PULLUP <= next_pin_pullup;
			PIN_RX_EN <= next_pin_rx_en;
			PIN_ROUTED <= next_pin_routed;
			PERIPH_IN <= next_periph_in;
		end
	end

endmodule

// ==== tb/pxb_checker.sv ====
// Purpose: Port pin and crossbar property checks
// Assumes: Config reaches the pins two edges after capture
// Notes: Bound to pxb_port_io
`timescale 1ns/1ps
`include "pxb_cfg.svh"
module pxb_checker (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire pxb_pkg::pxb_cfg_t CFG,
	input wire pxb_pkg::pxb_periph_t PERIPH,
	input wire logic [`PXB_NSLOTS-1:0] PERIPH_IN,
	input wire logic [`PXB_NPINS-1:0] PIN_IN,
	input wire logic [`PXB_NPINS-1:0] PIN_OUT,
	input wire logic [`PXB_NPINS-1:0] PIN_OE,
	input wire logic [`PXB_NPINS-1:0] PIN_PULLUP,
	input wire logic [`PXB_NPINS-1:0] PIN_RX_EN,
	input wire logic [`PXB_NPINS-1:0] PIN_ROUTED
);
	pxb_pkg::pxb_cfg_t p, c;
	logic [1:0] rs;
	wire [15:0] im = c.port_input_mode_reg;
	wire [15:0] om = c.port_output_mode_reg;
	wire ok = rs == 2'h3;
	wire on = ok && c.crossbar_enable_bit;
	// Config as seen by the pins now
	always_ff @(posedge CORE_CLK) begin
		p <= CFG;
		c <= p;
		rs <= RST ? 2'h0 : rs + {1'b0, rs != 2'h3};
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	a_analog_off: assert property (ok |-> ((PIN_OE | PIN_PULLUP | PIN_RX_EN) & ~im) == 16'h0)
		else $error("analog pin active");
	a_rx_digital: assert property (ok |-> PIN_RX_EN == im)
		else $error("receiver enable wrong");
	a_xbar_off: assert property (ok && !c.crossbar_enable_bit |-> (PIN_OE | PIN_ROUTED) == 16'h0)
		else $error("pin active with crossbar off");
	a_pullup_mode: assert property (ok && !c.smbus_en |-> PIN_PULLUP ==
		(~om & im & {16{~c.weak_pullup_disable_bit}} & ~(PIN_OE & ~PIN_OUT)))
		else $error("pullup wrong");
	a_pullup_low: assert property ((PIN_PULLUP & PIN_OE & ~PIN_OUT) == 16'h0)
		else $error("pullup on low pin");
	a_od_no_high: assert property (ok |-> (PIN_OE & PIN_OUT & ~om) == 16'h0)
		else $error("open-drain pin drives high");
	a_smbus_od: assert property (on && c.smbus_en && !c.spi_en && c.port_skip_reg == 16'h0
		|-> (PIN_OE[1:0] & PIN_OUT[1:0]) == 2'h0)
		else $error("bus pin drives high");
	a_uart_pins: assert property (on && c.uart_en |-> PIN_ROUTED[5:4] == 2'h3)
		else $error("uart pins not routed");
	a_skip_pass: assert property (on && !c.uart_en |-> (PIN_ROUTED & c.port_skip_reg) == 16'h0)
		else $error("skipped pin routed");
	a_port_drive: assert property (on |->
		((PIN_OE ^ (im & (om | ~c.port_latch_reg))) & ~PIN_ROUTED) == 16'h0)
		else $error("port drive wrong");
	c_routed: cover property (on && PIN_ROUTED != 16'h0);
	c_analog: cover property (ok && im != 16'hffff);
	c_low: cover property ((PIN_OE & ~PIN_OUT & ~om) != 16'h0);
endmodule
bind pxb_port_io pxb_checker chk (.CORE_CLK, .RST, .CFG, .PERIPH, .PERIPH_IN, .PIN_IN,
	.PIN_OUT, .PIN_OE, .PIN_PULLUP, .PIN_RX_EN, .PIN_ROUTED);

// ==== tb/pxb_pin_model.sv ====
// Purpose: External pin level model
// Assumes: Device drive wins, then external drive, then pullup
// Notes: Undriven unpulled pins toggle each cycle
`timescale 1ns/1ps
module pxb_pin_model (
	input wire logic clk,
	input wire logic [15:0] out,
	input wire logic [15:0] oe,
	input wire logic [15:0] pu,
	input wire logic [15:0] ext,
	input wire logic [15:0] ext_oe,
	output logic [15:0] level
);
	logic t = 1'b0;
	always_ff @(posedge clk) begin
		t <= ~t;
	end
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			level[i] = oe[i] ? out[i] : ext_oe[i] ? ext[i] : pu[i] | t;
		end
	end
endmodule

// ==== tb/pxb_testbench.sv ====
// Purpose: Self-checking bench for pxb_port_io
// Assumes: Checks three edges after each config change
// Notes: Pins resolved by pxb_pin_model
`timescale 1ns/1ps
`define CK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("FAIL %0t %h %h", $time, a, b); end end
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] ext_oe = 16'h0000;
	logic [15:0] pin_in, pin_out, pin_oe, pull, rx, routed;
	logic [11:0] p_in;
	pxb_pkg::pxb_cfg_t cfg, v;
	pxb_pkg::pxb_periph_t per, w;
	int num_errors = 0;
	int checked = 0;
	initial begin
		forever #12.5 clk = ~clk;
	end
	pxb_port_io dut (.CORE_CLK(clk), .RST(rst), .CFG(cfg), .PERIPH(per), .PERIPH_IN(p_in),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULLUP(pull),
		.PIN_RX_EN(rx), .PIN_ROUTED(routed));
	pxb_pin_model pins (.clk(clk), .out(pin_out), .oe(pin_oe), .pu(pull), .ext(16'h0000),
		.ext_oe(ext_oe), .level(pin_in));
	task stop_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task cf(input pxb_pkg::pxb_cfg_t n, input pxb_pkg::pxb_periph_t q);
		@(posedge clk);
		cfg <= n;
		per <= q;
		repeat (3) @(posedge clk);
		#1;
	endtask
	initial begin
		#100000;
		num_errors++;
		stop_test;
	end
	initial begin
		v = '0;
		v.port_input_mode_reg = 16'hffff;
		v.port_latch_reg = 16'hffff;
		w = '0;
		cfg = v;
		per = w;
		repeat (2) @(posedge clk);
		#1;
		`CK({pin_oe, pull, rx, routed, p_in}, 76'h0000ffffffff0000fff)
		@(posedge clk);
		rst <= 1'b0;
		// Modes, skips, assignments, then enable
		v.port_output_mode_reg = 16'hffff;
		v.port_skip_reg = 16'h000d;
		{v.uart_en, v.spi_en, v.spi_4wire, v.cca_mode} = 5'h1f;
		w.dout = 12'hfff;
		w.oe = 12'hff5;
		cf(v, w);
		`CK({pin_oe, routed, pull}, 48'h0)
		v.crossbar_enable_bit = 1'b1;
		cf(v, w);
		`CK(routed, 16'h0ff2)
		`CK(pin_oe | routed, 16'hffff)
		@(posedge clk);
		ext_oe <= 16'h0060;
		repeat (4) @(posedge clk);
		#1;
		`CK(p_in, 12'hff5)
		v.spi_4wire = 1'b0;
		cf(v, w);
		`CK(routed, 16'h07f2)
		// One capture/compare output and external counter input
		v.cca_mode = 2'h1;
		v.eci_en = 1'b1;
		cf(v, w);
		`CK(routed, 16'h03f2)
		v.eci_en = 1'b0;
		// Analog pins latched high and skipped
		v.port_input_mode_reg = 16'hfff3;
		v.port_output_mode_reg = 16'h0000;
		v.port_skip_reg = 16'h000c;
		{v.uart_en, v.spi_en, v.cca_mode} = 4'h0;
		cf(v, w);
		`CK({rx, pull, pin_oe}, 48'hfff3fff30000)
		v.weak_pullup_disable_bit = 1'b1;
		cf(v, w);
		`CK(pull, 16'h0000)
		v.weak_pullup_disable_bit = 1'b0;
		v.port_latch_reg = 16'hfffe;
		cf(v, w);
		`CK({pin_oe, pull}, 32'h0001fff2)
		v.port_latch_reg = 16'hffff;
		v.port_output_mode_reg = 16'hff00;
		cf(v, w);
		`CK({pull, pin_oe}, 32'h00f3ff00)
		v.port_input_mode_reg = 16'hffff;
		v.port_output_mode_reg = 16'hffff;
		v.port_skip_reg = 16'h0000;
		v.smbus_en = 1'b1;
		w.oe = 12'h0c0;
		w.dout = 12'h0c0;
		cf(v, w);
		`CK({routed, pin_oe[1:0]}, 18'h0000c)
		w.dout = 12'h000;
		cf(v, w);
		`CK({pin_oe[1:0], pin_out[1:0]}, 4'hc)
		stop_test;
	end
endmodule
